// >>> shared/sqstk_pkg.sv
// package: sequencer stack entry map, field layout and reset words
package sqstk_pkg;
    // printed offsets are not multiples of four: kept as indices, byte address = 4 * index
    localparam logic [5:0]  IDX_ENTRY_28   = 6'h3c;
    localparam logic [5:0]  IDX_ENTRY_29   = 6'h3d;
    localparam logic [5:0]  IDX_ENTRY_30   = 6'h3e;
    localparam logic [5:0]  IDX_ENTRY_31   = 6'h3f;
    localparam logic [5:0]  IDX_SEQ_CTRL   = 6'h20;
    localparam logic [5:0]  IDX_SEQ_STATUS = 6'h21;
    localparam int          NUM_ENTRIES    = 4;
    localparam logic [15:0] RST_ENTRY_28   = 16'h7800;
    localparam logic [15:0] RST_ENTRY_29   = 16'h7a00;
    localparam logic [15:0] RST_ENTRY_30   = 16'h7c00;
    localparam logic [15:0] RST_ENTRY_31   = 16'h7e00;
    localparam int          POS_DIR        = 15;
    localparam int          POS_SEL_HI     = 14;
    localparam int          POS_SEL_LO     = 9;
    localparam int          POS_RET        = 8;
    localparam int          POS_CHB_HI     = 7;
    localparam int          POS_CHB_LO     = 4;
    localparam int          POS_CHA_HI     = 3;
    localparam int          POS_CHA_LO     = 0;
    localparam int          POS_CTRL_EN    = 0;
    localparam logic [1:0]  FIRST_ENTRY    = 2'h0;

    typedef struct packed {
        logic       dir;
        logic [5:0] register_select_field;
        logic       stack_return_control;
        logic [3:0] converter_b_channel;
        logic [3:0] converter_a_channel;
    } sqstk_entry_t;

    typedef struct packed {
        logic [3:0] converter_a_channel;
        logic [3:0] converter_b_channel;
    } sqstk_chan_t;

    typedef enum logic [1:0] {
        SQ_IDLE,
        SQ_CONVERT,
        SQ_STEP
    } sqstk_state_t;
endpackage

// >>> logic/sqstk_entry.sv
// one sequencer stack entry: reset word, apb write and field split
`timescale 1ns/1ps
module sqstk_entry #(
    parameter logic [15:0] RESET_WORD = 16'h7800
) (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   wr_en,
    input  wire logic [15:0]            wr_data,
    output sqstk_pkg::sqstk_entry_t     entry
);
    sqstk_pkg::sqstk_entry_t entry_q;
    sqstk_pkg::sqstk_entry_t entry_d;

    always_comb begin
        entry_d = entry_q;
        if (wr_en) begin
            entry_d = sqstk_pkg::sqstk_entry_t'(wr_data);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            entry_q <= sqstk_pkg::sqstk_entry_t'(RESET_WORD);
        end else begin
            entry_q <= entry_d;
        end
    end

    assign entry = entry_q;

    property p_reset_word;
        @(posedge pclk) $rose(presetn) |-> entry_q == sqstk_pkg::sqstk_entry_t'(RESET_WORD);
    endproperty
    a_reset_word : assert property (p_reset_word)
        else $error("entry not at reset word after reset");

    // contents only move on a write strobe
    property p_hold;
        @(posedge pclk) disable iff (!presetn)
        !wr_en |=> entry_q == $past(entry_q);
    endproperty
    a_hold : assert property (p_hold)
        else $error("entry changed without a write");
endmodule

// >>> logic/sqstk_top.sv
// sequencer stack entries 28 to 31 behind apb, with a small step sequencer
`timescale 1ns/1ps
// Operation
// - bit 15: zero read, one write; stored in dir and read back only, the sequencer never reads or writes on it
// - bits 14:9 hold own address, reset
// - return clear: advance to next entry
// - return set: go back to first
// - bits 7:4 select converter b channel
// - bits 3:0 select converter a channel
// - entries at 0x3c.. with reset words
// - entry 31 at 0x3f, reset 0x7e00
module sqstk_top (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    input  wire logic [3:0]             pstrb,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic                   conv_done,
    output logic                        conv_start,
    output sqstk_pkg::sqstk_chan_t      chan_sel,
    output logic      [1:0]             active_entry
);
    localparam logic [15:0] RST_WORDS [sqstk_pkg::NUM_ENTRIES] = '{
        sqstk_pkg::RST_ENTRY_28, sqstk_pkg::RST_ENTRY_29,
        sqstk_pkg::RST_ENTRY_30, sqstk_pkg::RST_ENTRY_31};

    sqstk_pkg::sqstk_entry_t entries [sqstk_pkg::NUM_ENTRIES];
    logic [sqstk_pkg::NUM_ENTRIES-1:0] entry_wr;

    logic        access;
    logic [5:0]  idx;
    logic        addr_ok;
    logic        is_entry;
    logic [1:0]  ent_idx;

    // bus: one wait state, errors on unmapped or misaligned address
    assign access   = psel && penable;
    assign idx      = paddr[7:2];
    assign addr_ok  = paddr[1:0] == 2'h0;
    assign is_entry = addr_ok && idx >= sqstk_pkg::IDX_ENTRY_28;
    assign ent_idx  = idx[1:0];

    logic        run_q;
    logic        run_d;
    logic        pready_q;

    genvar g;
    generate
        for (g = 0; g < sqstk_pkg::NUM_ENTRIES; g++) begin : g_entry
            assign entry_wr[g] = access && pwrite && is_entry && ent_idx == 2'(g)
                                 && pstrb[1:0] == 2'h3 && !pready_q; // one store per transfer
            sqstk_entry #(
                .RESET_WORD (RST_WORDS[g])
            ) u_entry (
                .pclk    (pclk),
                .presetn (presetn),
                .wr_en   (entry_wr[g]),
                .wr_data (pwdata[15:0]),
                .entry   (entries[g])
            );
        end
    endgenerate

    // apb answer registers
    logic [31:0] prdata_d;
    logic        pready_d;
    logic        pslverr_d;
    logic [31:0] prdata_q;
    logic        pslverr_q;

    sqstk_pkg::sqstk_state_t state_q;
    sqstk_pkg::sqstk_state_t state_d;
    logic [1:0]  ptr_q;
    logic [1:0]  ptr_d;
    sqstk_pkg::sqstk_chan_t chan_q;
    sqstk_pkg::sqstk_chan_t chan_d;
    logic        start_q;
    logic        start_d;

    always_comb begin
        prdata_d  = 32'h0;
        pready_d  = 1'b0;
        pslverr_d = 1'b0;
        run_d     = run_q;
        if (psel && !pready_q) begin
            pready_d = penable;
            if (penable) begin
                if (is_entry) begin
                    if (!pwrite) begin
                        prdata_d = {16'h0, 16'(entries[ent_idx])};
                    end
                end else if (addr_ok && idx == sqstk_pkg::IDX_SEQ_CTRL) begin
                    if (pwrite && pstrb[0]) begin
                        run_d = pwdata[sqstk_pkg::POS_CTRL_EN];
                    end
                    prdata_d = {31'h0, run_q};
                end else if (addr_ok && idx == sqstk_pkg::IDX_SEQ_STATUS) begin
                    pslverr_d = pwrite;
                    prdata_d  = {27'h0, state_q == sqstk_pkg::SQ_CONVERT, 2'h0, ptr_q};
                end else begin
                    pslverr_d = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q  <= 32'h0;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            run_q     <= 1'b0;
        end else begin
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
            run_q     <= run_d;
        end
    end

    // sequencer: load channels, start, wait done, then step per return bit
    always_comb begin
        state_d = state_q;
        ptr_d   = ptr_q;
        chan_d  = chan_q;
        start_d = 1'b0;
        case (state_q)
            sqstk_pkg::SQ_IDLE: begin
                ptr_d = sqstk_pkg::FIRST_ENTRY;
                if (run_q) begin
                    state_d = sqstk_pkg::SQ_STEP;
                end
            end
            sqstk_pkg::SQ_STEP: begin
                // channels of the active entry go out before its return bit matters
                chan_d.converter_a_channel = entries[ptr_q].converter_a_channel;
                chan_d.converter_b_channel = entries[ptr_q].converter_b_channel;
                start_d = 1'b1;
                state_d = sqstk_pkg::SQ_CONVERT;
            end
            sqstk_pkg::SQ_CONVERT: begin
                // stop only between conversions so a sample is never cut short
                if (conv_done) begin
                    if (entries[ptr_q].stack_return_control) begin
                        ptr_d = sqstk_pkg::FIRST_ENTRY;
                    end else begin
                        ptr_d = ptr_q + 2'h1;
                    end
                    state_d = run_q ? sqstk_pkg::SQ_STEP : sqstk_pkg::SQ_IDLE;
                end
            end
            default: begin
                state_d = sqstk_pkg::SQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= sqstk_pkg::SQ_IDLE;
            ptr_q   <= sqstk_pkg::FIRST_ENTRY;
            chan_q  <= '0;
            start_q <= 1'b0;
        end else begin
            state_q <= state_d;
            ptr_q   <= ptr_d;
            chan_q  <= chan_d;
            start_q <= start_d;
        end
    end

    assign prdata       = prdata_q;
    assign pready       = pready_q;
    assign pslverr      = pslverr_q;
    assign conv_start   = start_q;
    assign chan_sel     = chan_q;
    assign active_entry = ptr_q;

    property p_write_dir;
        @(posedge pclk) disable iff (!presetn)
        entry_wr[0] |=> entries[0].dir == $past(pwdata[sqstk_pkg::POS_DIR]);
    endproperty
    a_write_dir : assert property (p_write_dir)
        else $error("direction bit not stored");

    property p_sel_field;
        @(posedge pclk) disable iff (!presetn)
        entry_wr[2] |=> entries[2].register_select_field
            == $past(pwdata[sqstk_pkg::POS_SEL_HI:sqstk_pkg::POS_SEL_LO]);
    endproperty
    a_sel_field : assert property (p_sel_field)
        else $error("address field not stored");

    property p_advance;
        @(posedge pclk) disable iff (!presetn)
        (state_q == sqstk_pkg::SQ_CONVERT && conv_done
            && !entries[ptr_q].stack_return_control) |=> ptr_q == $past(ptr_q) + 2'h1;
    endproperty
    a_advance : assert property (p_advance)
        else $error("sequencer did not advance");

    property p_return;
        @(posedge pclk) disable iff (!presetn)
        (state_q == sqstk_pkg::SQ_CONVERT && conv_done
            && entries[ptr_q].stack_return_control) |=> ptr_q == sqstk_pkg::FIRST_ENTRY;
    endproperty
    a_return : assert property (p_return)
        else $error("sequencer did not return to first entry");

    property p_chan_b;
        @(posedge pclk) disable iff (!presetn)
        $rose(conv_start) |-> chan_sel.converter_b_channel
            == $past(entries[ptr_q].converter_b_channel);
    endproperty
    a_chan_b : assert property (p_chan_b)
        else $error("converter b channel mismatch");

    property p_chan_a;
        @(posedge pclk) disable iff (!presetn)
        $rose(conv_start) |-> chan_sel.converter_a_channel
            == $past(entries[ptr_q].converter_a_channel);
    endproperty
    a_chan_a : assert property (p_chan_a)
        else $error("converter a channel mismatch");

    property p_read_back;
        @(posedge pclk) disable iff (!presetn)
        (access && !pwrite && is_entry && !pready_q) |=> pready_q
            && prdata_q[15:0] == 16'($past(entries[ent_idx]));
    endproperty
    a_read_back : assert property (p_read_back)
        else $error("entry read data wrong");

    property p_entry31;
        @(posedge pclk) $rose(presetn) |-> 16'(entries[3]) == sqstk_pkg::RST_ENTRY_31;
    endproperty
    a_entry31 : assert property (p_entry31)
        else $error("last entry reset word wrong");

    property p_start_order;
        @(posedge pclk) disable iff (!presetn)
        conv_start |=> !conv_start ##0 state_q == sqstk_pkg::SQ_CONVERT;
    endproperty
    a_start_order : assert property (p_start_order)
        else $error("start not followed by conversion wait");

    c_return  : cover property (@(posedge pclk) disable iff (!presetn)
        state_q == sqstk_pkg::SQ_CONVERT && conv_done && entries[ptr_q].stack_return_control);
    c_wrap    : cover property (@(posedge pclk) disable iff (!presetn)
        ptr_q == 2'h3 ##1 ptr_q == 2'h0);
    c_write   : cover property (@(posedge pclk) disable iff (!presetn) entry_wr[1]);
    c_slverr  : cover property (@(posedge pclk) disable iff (!presetn) pslverr_q);
endmodule

// >>> test/sqstk_conv_model.sv
// converter stand-in: answers each conversion start after a set delay
`timescale 1ns/1ps
module sqstk_conv_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       conv_start,
    input  wire logic [3:0] dly,
    output logic            conv_done
);
    logic [4:0] cnt_q;
    // zero means idle; done pulses one cycle as the count runs out
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q     <= 5'h00;
            conv_done <= 1'b0;
        end else begin
            conv_done <= (cnt_q == 5'h01);
            if (conv_start) begin
                cnt_q <= {1'b0, dly} + 5'h01;
            end else if (cnt_q != 5'h00) begin
                cnt_q <= cnt_q - 5'h01;
            end
        end
    end
endmodule

// >>> test/testbench.sv
// self-checking bench: apb register checks and sequencer stepping
`timescale 1ns/1ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin n_fail++; \
    $display("Error t=%0t got %h exp %h", $time, (got), (exp)); end end
module testbench;
    logic                   pclk = 1'b0;
    logic                   presetn = 1'b0;
    logic                   psel = 1'b0;
    logic                   penable = 1'b0;
    logic                   pwrite = 1'b0;
    logic [7:0]             paddr = 8'h00;
    logic [31:0]            pwdata = 32'h0000_0000;
    logic [3:0]             pstrb = 4'h0;
    logic [3:0]             dly = 4'h0;
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
    logic                   conv_done;
    logic                   conv_start;
    sqstk_pkg::sqstk_chan_t chan_sel;
    logic [1:0]             active_entry;
    int                     n_fail = 0;
    int                     num_checks = 0;
    integer                 seed = 32'ha280;
    logic [33:0]            rq[$];
    logic [9:0]             cq[$];
    logic [15:0]            ent[4];
    logic [15:0]            rst_w[4];

    always #4 pclk = ~pclk;

    sqstk_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .conv_done(conv_done), .conv_start(conv_start),
        .chan_sel(chan_sel), .active_entry(active_entry));

    sqstk_conv_model conv (.pclk(pclk), .presetn(presetn), .conv_start(conv_start),
        .dly(dly), .conv_done(conv_done));

    task stop_test;
        $display("checks %0d errors %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    function automatic logic [7:0] addr(input int i);
        return {sqstk_pkg::IDX_ENTRY_28 + 6'(i), 2'b00};
    endfunction

    // called just after a rising edge; leaves one idle cycle behind
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
             input logic err, input logic [31:0] e);
        rq.push_back({~w, err, e});
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        // no answer time assumed: only the watchdog ends a hang
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task cfg(input int ret_idx);
        for (int i = 0; i < 4; i++) begin
            ent[i] = 16'($random(seed));
            ent[i][15] = 1'b1;
            ent[i][14:9] = sqstk_pkg::IDX_ENTRY_28 + 6'(i);
            ent[i][8] = (i == ret_idx);
            apb(1'b1, addr(i), {16'($random(seed)), ent[i]}, {2'($random(seed)), 2'b11},
                1'b0, 32'h0);
            apb(1'b0, addr(i), 32'h0, 4'hf, 1'b0, {16'h0000, ent[i]});
        end
    endtask

    task run(input int n, input logic [3:0] d);
        logic [1:0] p;
        int         k;
        p = sqstk_pkg::FIRST_ENTRY;
        for (k = 0; k < n; k++) begin
            cq.push_back({p, ent[p][3:0], ent[p][7:4]});
            p = ent[p][8] ? sqstk_pkg::FIRST_ENTRY : p + 2'h1;
        end
        dly <= d;
        apb(1'b1, 8'h80, 32'h1, 4'hf, 1'b0, 32'h0);
        k = 0;
        while (cq.size() > 0 && k < 2000) begin
            @(posedge pclk);
            k++;
        end
        if (k == 2000)
            n_fail++;
        apb(1'b1, 8'h80, 32'h0, 4'hf, 1'b0, 32'h0);
        repeat (40) @(posedge pclk);
    endtask

    always @(posedge pclk) begin
        logic [33:0] e;
        if (pready === 1'b1 && rq.size() > 0) begin
            e = rq.pop_front();
            `CHK(pslverr, e[32])
            if (e[33])
                `CHK(prdata, e[31:0])
        end
    end

    // starts after a stop request are legal, so an empty queue is skipped
    always @(posedge pclk) begin
        logic [9:0] ce;
        if (conv_start === 1'b1 && cq.size() > 0) begin
            ce = cq.pop_front();
            `CHK({active_entry, chan_sel}, ce)
        end
    end

    initial begin
        #200000;
        n_fail++;
        stop_test();
    end

    initial begin
        rst_w = '{sqstk_pkg::RST_ENTRY_28, sqstk_pkg::RST_ENTRY_29,
                  sqstk_pkg::RST_ENTRY_30, sqstk_pkg::RST_ENTRY_31};
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int r = 0; r < 2; r++) begin
            for (int i = 0; i < 4; i++)
                apb(1'b0, addr(i), 32'h0, 4'hf, 1'b0, {16'h0000, rst_w[i]});
            apb(1'b1, addr(0), 32'h0000_ffff, 4'b1101, 1'b0, 32'h0);
            apb(1'b0, addr(0), 32'h0, 4'hf, 1'b0, {16'h0000, rst_w[0]});
            apb(1'b0, 8'hf1, 32'h0, 4'hf, 1'b1, 32'h0);
            apb(1'b0, 8'h10, 32'h0, 4'hf, 1'b1, 32'h0);
            apb(1'b1, 8'h84, 32'h1, 4'hf, 1'b1, 32'h0);
            cfg(r == 0 ? 2 : 4);
            run(6, r == 0 ? 4'h0 : 4'($random(seed)));
            presetn <= 1'b0;
            repeat (3) @(posedge pclk);
            presetn <= 1'b1;
            @(posedge pclk);
        end
        stop_test();
    end
endmodule
